/* rtl/instr_timing.sv */
// state sequencer for arithmetic and logical instruction timing
`timescale 1ns/100ps
`default_nettype none
module instr_timing (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic source_mode_i,
  input wire logic start_i,
  input wire instr_timing_pkg::form_t form_i,
  input wire logic [7:0] dir_addr_i,
  input wire logic [1:0] step_sel_i,
  input wire logic [31:0] operand_i,
  output logic busy_o,
  output logic done_o,
  output logic [2:0] length_o,
  output logic [5:0] states_o,
  output logic write_dest_o,
  output logic [31:0] step_result_o,
  output logic step_illegal_o,
  output logic source_mode_o
);
  import instr_timing_pkg::*;

  // ****************************************
  // opcode mode latch
  // ****************************************
  // caught one clock after release so reset never loads a port value
  logic mode_latched;
  logic mode_source;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_latched <= 1'b0;
      mode_source <= MODE_BINARY_RESET;
    end else if (!mode_latched) begin
      mode_latched <= 1'b1;
      mode_source <= source_mode_i;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  logic [3:0] step;
  logic step_legal;
  step_select u_step (
    .sel_i(step_sel_i),
    .step_o(step),
    .legal_o(step_legal)
  );

  // unknown codes are refused: the table has no row for them
  logic [FORM_COUNT-1:0] form_hit;
  genvar fi;
  generate
    for (fi = 0; fi < FORM_COUNT; fi++) begin : g_form
      assign form_hit[fi] = (form_i == 6'(fi));
    end
  endgenerate
  wire form_known = |form_hit;
  wire [4:0] table_index = form_known ? form_i[4:0] : 5'h00;
  wire timing_t entry = TIMING_TABLE[table_index];

  localparam logic [7:0] PORT_ADDR [4] = '{PORT_ADDR_0, PORT_ADDR_1, PORT_ADDR_2, PORT_ADDR_3};
  logic [3:0] port_hit;
  genvar pi;
  generate
    for (pi = 0; pi < $size(PORT_ADDR); pi++) begin : g_port
      assign port_hit[pi] = (dir_addr_i == PORT_ADDR[pi]);
    end
  endgenerate
  wire is_port = |port_hit;
  // forms with no direct operand carry port_extra of zero in the table
  wire [1:0] extra = is_port ? entry.port_extra : 2'h0;
  wire [4:0] base_states = mode_source ? entry.src_states : entry.bin_states;
  wire [2:0] base_bytes = mode_source ? entry.src_bytes : entry.bin_bytes;
  wire [5:0] total_states = {1'b0, base_states} + {4'h0, extra};
  wire is_short = (form_i == F_INC_B) || (form_i == F_INC_W) || (form_i == F_INC_D);
  wire [31:0] step_wide = {28'h0, step};
  wire [31:0] next_step_result = operand_i + step_wide;
  state_t state;
  state_t next_state;
  logic [5:0] count;
  wire accept = start_i && (state == ST_IDLE) && mode_latched && form_known;

  // ****************************************
  // sequencer
  // ****************************************
  assign next_state = (state == ST_IDLE) ? (accept ? ST_RUN : ST_IDLE) :
                      (state == ST_RUN) ? ((count == 6'h1) ? ST_DONE : ST_RUN) :
                      ST_IDLE;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= next_state;
        ST_RUN: state <= next_state;
        ST_DONE: state <= next_state;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // one state per clock; done follows the last counted state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 6'h0;
    end else if (accept) begin
      count <= total_states;
    end else if (state == ST_RUN) begin
      count <= count - 6'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      length_o <= 3'h0;
      states_o <= 6'h0;
      write_dest_o <= 1'b0;
      step_result_o <= 32'h0;
      step_illegal_o <= 1'b0;
    end else if (accept) begin
      length_o <= base_bytes;
      states_o <= total_states;
      write_dest_o <= entry.writes_dest;
      step_result_o <= is_short ? next_step_result : operand_i;
      step_illegal_o <= is_short && !step_legal;
    end
  end

  // table also holds forms
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      source_mode_o <= MODE_BINARY_RESET;
    end else begin
      busy_o <= (next_state == ST_RUN);
      done_o <= (state == ST_RUN) && (count == 6'h1);
      source_mode_o <= mode_source;
    end
  end
endmodule // instr_timing
`default_nettype wire

/* rtl/instr_timing_pkg.sv */
// constants and types for the arithmetic and logical instruction timing unit
package instr_timing_pkg;

  // ****************************************
  // instruction forms
  // ****************************************
  typedef enum logic [5:0] {
    F_MUL_B = 6'h00, F_MUL_W = 6'h01, F_DIV_B = 6'h02, F_DIV_W = 6'h03,
    F_ADD_B = 6'h04, F_ADD_W = 6'h05, F_ADD_D = 6'h06, F_ADD_DIMM = 6'h07,
    F_CMP_DIMM1 = 6'h08, F_CMP_B_IDR = 6'h09, F_ADC_IND = 6'h0A, F_ADC_REG = 6'h0B,
    F_INC_B = 6'h0C, F_INC_W = 6'h0D, F_INC_D = 6'h0E, F_INC_DIR = 6'h0F,
    F_LOG_DIR_IMM = 6'h10, F_ROT_LC = 6'h11, F_LOG_W_DIR16 = 6'h12,
    F_ADD_B_DIR = 6'h13, F_LOG_A_DIR = 6'h14, F_CMP_B_DIR = 6'h15
  } form_t;
  localparam int FORM_COUNT = 22;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } state_t;

  // ****************************************
  // timing table entries
  // ****************************************
  typedef struct packed {
    logic [2:0] bin_bytes;
    logic [4:0] bin_states;
    logic [2:0] src_bytes;
    logic [4:0] src_states;
    logic [1:0] port_extra;
    logic writes_dest;
  } timing_t;

  localparam logic [1:0] PORT_EXTRA_ONE = 2'h1;
  localparam logic [1:0] PORT_EXTRA_TWO = 2'h2;
  localparam logic [7:0] PORT_ADDR_0 = 8'h80;
  localparam logic [7:0] PORT_ADDR_1 = 8'h90;
  localparam logic [7:0] PORT_ADDR_2 = 8'hA0;
  localparam logic [7:0] PORT_ADDR_3 = 8'hB0;
  localparam logic [1:0] STEP_SEL_1 = 2'h0;
  localparam logic [1:0] STEP_SEL_2 = 2'h1;
  localparam logic [1:0] STEP_SEL_4 = 2'h2;
  localparam logic MODE_BINARY_RESET = 1'b0;

  localparam timing_t TIMING_TABLE [FORM_COUNT] = '{
    '{3'h3, 5'h06, 3'h2, 5'h05, 2'h0, 1'b1},
    '{3'h3, 5'h0C, 3'h2, 5'h0B, 2'h0, 1'b1},
    '{3'h3, 5'h0B, 3'h2, 5'h0A, 2'h0, 1'b1},
    '{3'h3, 5'h15, 3'h2, 5'h14, 2'h0, 1'b1},
    '{3'h3, 5'h02, 3'h2, 5'h01, 2'h0, 1'b1},
    '{3'h3, 5'h03, 3'h2, 5'h02, 2'h0, 1'b1},
    '{3'h3, 5'h05, 3'h2, 5'h04, 2'h0, 1'b1},
    '{3'h5, 5'h06, 3'h4, 5'h05, 2'h0, 1'b1},
    '{3'h5, 5'h06, 3'h4, 5'h05, 2'h0, 1'b0},
    '{3'h4, 5'h04, 3'h3, 5'h03, 2'h0, 1'b0},
    '{3'h1, 5'h02, 3'h2, 5'h03, 2'h0, 1'b1},
    '{3'h1, 5'h01, 3'h2, 5'h02, 2'h0, 1'b1},
    '{3'h3, 5'h02, 3'h2, 5'h01, 2'h0, 1'b1},
    '{3'h3, 5'h02, 3'h2, 5'h01, 2'h0, 1'b1},
    '{3'h3, 5'h04, 3'h2, 5'h03, 2'h0, 1'b1},
    '{3'h2, 5'h02, 3'h2, 5'h02, 2'h2, 1'b1},
    '{3'h3, 5'h03, 3'h3, 5'h03, 2'h2, 1'b1},
    '{3'h1, 5'h01, 3'h1, 5'h01, 2'h0, 1'b1},
    '{3'h5, 5'h04, 3'h4, 5'h03, 2'h0, 1'b1},
    '{3'h4, 5'h03, 3'h3, 5'h02, 2'h1, 1'b1},
    '{3'h2, 5'h01, 3'h2, 5'h01, 2'h1, 1'b1},
    '{3'h4, 5'h03, 3'h3, 5'h02, 2'h1, 1'b0}
  };

endpackage

/* rtl/step_select.sv */
// short-immediate step decoder
`timescale 1ns/100ps
`default_nettype none
module step_select (
  input wire logic [1:0] sel_i,
  output logic [3:0] step_o,
  output logic legal_o
);
  import instr_timing_pkg::*;
  // reserved code 11 reports illegal; step falls back to 1
  assign step_o = (sel_i == STEP_SEL_4) ? 4'h4 : (sel_i == STEP_SEL_2) ? 4'h2 : 4'h1;
  assign legal_o = (sel_i == STEP_SEL_1) || (sel_i == STEP_SEL_2) || (sel_i == STEP_SEL_4);
endmodule // step_select
`default_nettype wire

/* test/instr_timing_chk.sv */
// assertion checker for the instruction timing unit
`timescale 1ns/100ps
`default_nettype none
module instr_timing_chk
  import instr_timing_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire instr_timing_pkg::form_t form_i,
  input wire logic [1:0] step_sel_i,
  input wire logic [31:0] operand_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [5:0] states_o,
  input wire logic write_dest_o,
  input wire logic [31:0] step_result_o,
  input wire logic source_mode_o
);
  // ********
  // assertions
  // ********
  logic [5:0] cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // counts busy cycles so the done pulse is tied to the reported count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) cnt <= 6'h00;
    else cnt <= busy_o ? cnt + 6'h01 : 6'h00;
  end
  mul_byte_a: assert property (
    $rose(busy_o) && $past(form_i) == F_MUL_B |-> states_o == (source_mode_o ? 6'h05 : 6'h06))
    else $error("byte mul count");
  mul_word_a: assert property (
    $rose(busy_o) && $past(form_i) == F_MUL_W |-> states_o == (source_mode_o ? 6'h0B : 6'h0C))
    else $error("word mul count");
  div_byte_a: assert property (
    $rose(busy_o) && $past(form_i) == F_DIV_B |-> states_o == (source_mode_o ? 6'h0A : 6'h0B))
    else $error("byte div count");
  div_word_a: assert property (
    $rose(busy_o) && $past(form_i) == F_DIV_W |-> states_o == (source_mode_o ? 6'h14 : 6'h15))
    else $error("word div count");
  cmp_no_write_a: assert property (
    $rose(busy_o) && $past(form_i) == F_CMP_DIMM1 |-> !write_dest_o) else $error("cmp writes");
  inc_step_a: assert property (
    $rose(busy_o) && $past(form_i) == F_INC_W && $past(step_sel_i) == STEP_SEL_4
    |-> step_result_o == $past(operand_i) + 32'h4) else $error("step of four");
  done_count_a: assert property (
    done_o |-> cnt == states_o) else $error("busy length");
  done_pulse_a: assert property (
    done_o |=> !done_o && !busy_o) else $error("done pulse");
endmodule // instr_timing_chk
bind instr_timing instr_timing_chk chk (.clk_i, .reset_i, .form_i, .step_sel_i, .operand_i,
  .busy_o, .done_o, .states_o, .write_dest_o, .step_result_o, .source_mode_o);
`default_nettype wire

/* test/arith_logic_instr_timing_bench.sv */
// self-checking bench for the instruction timing unit
`timescale 1ns/100ps
`default_nettype none
module arith_logic_instr_timing_bench;
  import instr_timing_pkg::*;
  // ********
  // harness
  // ********
  logic clk_i = 0, reset_i = 1, source_mode_i = 0, start_i = 0, m = 0;
  form_t form_i = F_MUL_B;
  logic [7:0] dir_addr_i = 8'h20;
  logic [1:0] step_sel_i = 2'h0;
  logic [31:0] operand_i = 32'h00001000;
  logic busy_o, done_o, write_dest_o, step_illegal_o, source_mode_o;
  logic [2:0] length_o;
  logic [5:0] states_o;
  logic [31:0] step_result_o;
  int n_mismatch = 0, num_checks = 0;
  always #5 clk_i = ~clk_i;
  instr_timing DUT (.clk_i, .reset_i, .source_mode_i, .start_i, .form_i, .dir_addr_i,
    .step_sel_i, .operand_i, .busy_o, .done_o, .length_o, .states_o, .write_dest_o,
    .step_result_o, .step_illegal_o, .source_mode_o);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset();
    reset_i = 1;
    source_mode_i = m;
    repeat (2) @(posedge clk_i);
    #1 reset_i = 0;
    repeat (2) @(posedge clk_i);
    #1 check(source_mode_o, m);
  endtask
  // binary and source figures given; the latched mode picks one
  task automatic op(input form_t f, input logic [7:0] a, input logic [2:0] lb, input logic [2:0] ls,
    input logic [5:0] sb, input logic [5:0] ss);
    int k;
    form_i = f;
    dir_addr_i = a;
    start_i = 1;
    @(posedge clk_i);
    #1 start_i = 0;
    k = 1;
    check(length_o, m ? ls : lb);
    check(states_o, m ? ss : sb);
    while (done_o !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      #1 k++;
    end
    if (k >= 40) begin
      n_mismatch++;
      print_verdict();
    end else begin
      check(k, (m ? ss : sb) + 1);
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic t_muldiv();
    op(F_MUL_B, 8'h20, 3'h3, 3'h2, 6'h06, 6'h05);
    op(F_MUL_W, 8'h20, 3'h3, 3'h2, 6'h0C, 6'h0B);
    op(F_DIV_B, 8'h20, 3'h3, 3'h2, 6'h0B, 6'h0A);
    op(F_DIV_W, 8'h20, 3'h3, 3'h2, 6'h15, 6'h14);
    $display("muldiv end");
  endtask
  task automatic t_arith();
    op(F_ADD_B, 8'h20, 3'h3, 3'h2, 6'h02, 6'h01);
    op(F_ADD_W, 8'h20, 3'h3, 3'h2, 6'h03, 6'h02);
    op(F_ADD_D, 8'h20, 3'h3, 3'h2, 6'h05, 6'h04);
    op(F_ADD_DIMM, 8'h20, 3'h5, 3'h4, 6'h06, 6'h05);
    op(F_CMP_DIMM1, 8'h20, 3'h5, 3'h4, 6'h06, 6'h05);
    check(write_dest_o, 0);
    op(F_CMP_B_IDR, 8'h20, 3'h4, 3'h3, 6'h04, 6'h03);
    op(F_ADC_IND, 8'h20, 3'h1, 3'h2, 6'h02, 6'h03);
    op(F_ADC_REG, 8'h20, 3'h1, 3'h2, 6'h01, 6'h02);
    $display("arith end");
  endtask
  task automatic t_logic();
    op(F_LOG_DIR_IMM, 8'h20, 3'h3, 3'h3, 6'h03, 6'h03);
    op(F_LOG_DIR_IMM, PORT_ADDR_3, 3'h3, 3'h3, 6'h05, 6'h05);
    op(F_ADD_B_DIR, PORT_ADDR_0, 3'h4, 3'h3, 6'h04, 6'h03);
    op(F_LOG_A_DIR, PORT_ADDR_1, 3'h2, 3'h2, 6'h02, 6'h02);
    op(F_CMP_B_DIR, PORT_ADDR_2, 3'h4, 3'h3, 6'h04, 6'h03);
    check(write_dest_o, 0);
    op(F_ADD_B, PORT_ADDR_0, 3'h3, 3'h2, 6'h02, 6'h01);
    op(F_ROT_LC, 8'h20, 3'h1, 3'h1, 6'h01, 6'h01);
    op(F_LOG_W_DIR16, 8'h20, 3'h5, 3'h4, 6'h04, 6'h03);
    $display("logic end");
  endtask
  task automatic t_inc();
    for (int s = 0; s < 4; s++) begin
      step_sel_i = s[1:0];
      op(F_INC_W, 8'h20, 3'h3, 3'h2, 6'h02, 6'h01);
      check(step_result_o, operand_i + ((s == 3) ? 32'h1 : (32'h1 << s)));
      check(step_illegal_o, s == 3);
    end
    step_sel_i = STEP_SEL_4;
    op(F_INC_B, 8'h20, 3'h3, 3'h2, 6'h02, 6'h01);
    check(step_result_o, operand_i + 32'h4);
    op(F_INC_D, 8'h20, 3'h3, 3'h2, 6'h04, 6'h03);
    check(step_result_o, operand_i + 32'h4);
    op(F_INC_DIR, 8'h20, 3'h2, 3'h2, 6'h02, 6'h02);
    op(F_INC_DIR, PORT_ADDR_2, 3'h2, 3'h2, 6'h04, 6'h04);
    $display("inc end");
  endtask
  initial begin
    for (int i = 0; i < 2; i++) begin
      m = i[0];
      do_reset();
      t_muldiv();
      t_arith();
      t_logic();
      t_inc();
    end
    print_verdict();
  end
endmodule // arith_logic_instr_timing_bench
`default_nettype wire
